// *** hw/scfg_pkg.sv ***
package scfg_pkg;

    // ******************************************
    // register map: word index, byte address = 4 * index
    // ******************************************
    localparam int NUM_REGS = 5;
    localparam logic [2:0] IDX_LOCAL_ADDR = 3'h0;
    localparam logic [2:0] IDX_REMOTE_ADDR = 3'h1;
    localparam logic [2:0] IDX_SPREAD_AUDIO = 3'h2;
    localparam logic [2:0] IDX_SPREAD_CAL = 3'h3;
    localparam logic [2:0] IDX_LINK_CTRL = 3'h4;
    // highest word index covered by the write lock
    localparam logic [7:0] LOCK_LAST_IDX = 8'h1F;

    // ******************************************
    // field positions
    // ******************************************
    localparam int ADDR_LSB = 1;
    localparam int LOCK_BIT = 0;
    localparam int SPREAD_LSB = 5;
    localparam int AUDIO_BIT = 4;
    localparam int PCLK_LSB = 2;
    localparam int RATE_LSB = 0;
    localparam int RECAL_LSB = 6;
    localparam int SAW_LSB = 0;
    localparam int SER_BIT = 7;
    localparam int CLINK_BIT = 6;
    localparam int PRBS_BIT = 5;
    localparam int SLEEP_BIT = 4;
    localparam int PERIPH_LSB = 2;
    localparam int REV_BIT = 1;
    localparam int FWD_BIT = 0;

    // ******************************************
    // reset values and write masks
    // ******************************************
    localparam logic [1:0] LOCAL_ADDR_MID = 2'h0;
    localparam logic [1:0] REMOTE_ADDR_MID = 2'h1;
    localparam logic [7:0] SPREAD_AUDIO_RST = 8'h1F;
    localparam logic [7:0] SPREAD_CAL_RST = 8'h00;
    localparam logic [7:0] LINK_CTRL_RST = 8'h03;
    localparam logic [2:0] SPREAD_PIN_CODE = 3'h1;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_REMOTE = 8'hFE;
    localparam logic [1:0] RANGE_AUTO = 2'h3;
    localparam logic [1:0] PERIPH_I2C = 2'h0;
    localparam logic [1:0] PERIPH_UART = 2'h1;
    localparam logic [5:0] SAW_AUTO = 6'h00;
    localparam logic [1:0] RECAL_ONCE = 2'h0;
    localparam logic [1:0] RECAL_2MS = 2'h1;
    localparam logic [1:0] RECAL_16MS = 2'h2;
    // spread amplitude in steps of 0.5 percent, indexed by the field
    localparam logic [3:0] SPREAD_HALF_PCT [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h0, 4'h2, 4'h6, 4'h8};

    // ******************************************
    // timing
    // ******************************************
    localparam int CLK_MHZ = 250;
    localparam int STRAP_SETTLE_CYC = 3;
    localparam int REVCC_HOLD_US = 350;
    localparam int RECAL_2MS_US = 2000;
    localparam int RECAL_16MS_US = 16000;
    localparam int RECAL_256MS_US = 256000;
    localparam int REVCC_HOLD_CYC = REVCC_HOLD_US * CLK_MHZ;
    localparam int RECAL_2MS_CYC = RECAL_2MS_US * CLK_MHZ;
    localparam int RECAL_16MS_CYC = RECAL_16MS_US * CLK_MHZ;
    localparam int RECAL_256MS_CYC = RECAL_256MS_US * CLK_MHZ;

    typedef enum logic {SCFG_SETTLE, SCFG_RUN} scfg_state_t;

endpackage

// *** hw/scfg_regs.sv ***
`timescale 1ns/10ps
// Function
// - the local link address sits in bits 7..1 of register 0, loaded from the address straps at power-up.
// - while the lock bit (register 0 bit 0) is set, writes to word indices 0..0x1F are ignored.
// - the remote address sits in bits 7..1 of register 1 from the straps, bit 0 reads zero.
// - the spread select field maps to none/0.5/1.5/2/none/1/3/4 percent, reset 001 with spread_pin high else 000.
// - pixel_clk_range picks a fixed range or, at 11 (reset), automatic detection.
// - serial_rate_range picks a fixed rate band or, at 11 (reset), automatic detection.
// - after lock the spread rate is recalibrated once, or every 2, 16 or 256 ms.
// - a zero sawtooth_divider means autocalibrate, any other value is used as the divider.
// - serial_link_on (register 4 bit 7) enables the link, reset is the inverse of auto_start_pin.
// - every register write that starts or stops the link makes the reverse channel unavailable for 350 us.
// - the sleep bit (register 4 bit 4) selects sleep mode, reset taken from control_side_pin and auto_start_pin.
// - base_periph_select chooses I2C (00), UART (01) or no peripheral interface.
// - reverse_channel_on (register 4 bit 1, reset 1) enables reception of the reverse channel.
// - forward_channel_on (register 4 bit 0, reset 1) enables sending of the forward channel.
module scfg_regs #(
    parameter int ADDR_W = 12,
    parameter int REVCC_HOLD_CYC = scfg_pkg::REVCC_HOLD_CYC,
    parameter int RECAL_2MS_CYC = scfg_pkg::RECAL_2MS_CYC,
    parameter int RECAL_16MS_CYC = scfg_pkg::RECAL_16MS_CYC,
    parameter int RECAL_256MS_CYC = scfg_pkg::RECAL_256MS_CYC
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // strap pins and link status
    input wire logic [1:0] ADDR_STRAP_LOW_I,
    input wire logic [1:0] ADDR_STRAP_HIGH_I,
    input wire logic SPREAD_PIN_I,
    input wire logic AUTO_START_PIN_I,
    input wire logic CONTROL_SIDE_PIN_I,
    input wire logic LINK_LOCK_I,
    // configuration outputs
    output logic [6:0] LOCAL_DEV_ADDR_O,
    output logic [6:0] REMOTE_DEV_ADDR_O,
    output logic CONFIG_WRITE_LOCK_O,
    output logic [3:0] SPREAD_HALF_PCT_O,
    output logic [1:0] PIXEL_CLK_RANGE_O,
    output logic PIXEL_CLK_AUTO_O,
    output logic [1:0] SERIAL_RATE_RANGE_O,
    output logic SERIAL_RATE_AUTO_O,
    output logic SPREAD_RECAL_O,
    output logic [5:0] SAWTOOTH_DIVIDER_O,
    output logic SAWTOOTH_AUTO_O,
    output logic AUDIO_CHANNEL_ON_O,
    output logic SERIAL_LINK_ON_O,
    output logic CONFIG_LINK_ON_O,
    output logic PRBS_TEST_ON_O,
    output logic SLEEP_O,
    output logic PERIPH_I2C_O,
    output logic PERIPH_UART_O,
    output logic REVERSE_CHANNEL_ON_O,
    output logic FORWARD_CHANNEL_ON_O
);
    // ******************************************
    // elaboration checks
    // ******************************************
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
        $error("scfg_regs: ADDR_W must be 8 to 32");
    end
    if (REVCC_HOLD_CYC < 1 || RECAL_2MS_CYC < 1 || RECAL_16MS_CYC < 1 || RECAL_256MS_CYC < 1) begin : g_bad_cnt
        $error("scfg_regs: timing counts must be at least 1");
    end
    if (RECAL_256MS_CYC >= (1 << 27) || REVCC_HOLD_CYC >= (1 << 17)) begin : g_big_cnt
        $error("scfg_regs: timing count too wide for its counter");
    end

    // ******************************************
    // pin synchronisers
    // ******************************************
    logic [7:0] pins_sync;
    scfg_sync #(.W(8)) u_pin_sync (
        .clk_i(SYS_CLK_I),
        .rstn_i(RSTN_I),
        .async_i({LINK_LOCK_I, CONTROL_SIDE_PIN_I, AUTO_START_PIN_I, SPREAD_PIN_I,
                  ADDR_STRAP_HIGH_I, ADDR_STRAP_LOW_I}),
        .sync_o(pins_sync)
    );
    logic [1:0] strap_low;
    logic [1:0] strap_high;
    logic spread_pin;
    logic auto_start_pin;
    logic control_side_pin;
    logic link_lock;
    assign strap_low = pins_sync[1:0];
    assign strap_high = pins_sync[3:2];
    assign spread_pin = pins_sync[4];
    assign auto_start_pin = pins_sync[5];
    assign control_side_pin = pins_sync[6];
    assign link_lock = pins_sync[7];

    // ******************************************
    // startup: straps settle, then reset values load
    // ******************************************
    scfg_pkg::scfg_state_t state_reg, state_next;
    logic [1:0] settle_reg, settle_next;
    logic load_now;

    // straps are caught by the clock after release, never by the async reset
    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        load_now = 1'b0;
        case (state_reg)
            scfg_pkg::SCFG_SETTLE: begin
                if (settle_reg == 2'(scfg_pkg::STRAP_SETTLE_CYC - 1)) begin
                    load_now = 1'b1;
                    state_next = scfg_pkg::SCFG_RUN;
                end else begin
                    settle_next = settle_reg + 2'h1;
                end
            end
            scfg_pkg::SCFG_RUN: begin
                state_next = scfg_pkg::SCFG_RUN;
            end
            default: begin
                state_next = scfg_pkg::SCFG_SETTLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_reg <= scfg_pkg::SCFG_SETTLE;
            settle_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
        end
    end

    // ******************************************
    // apb slave and register storage
    // ******************************************
    logic [7:0] regs_reg [scfg_pkg::NUM_REGS];
    logic [7:0] regs_next [scfg_pkg::NUM_REGS];
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [ADDR_W-3:0] word_idx;
    logic mapped;
    logic wr_fire;
    logic [7:0] wmask;

    assign word_idx = PADDR_I[ADDR_W-1:2];
    assign mapped = (PADDR_I[1:0] == 2'h0) && (word_idx < (ADDR_W-2)'(scfg_pkg::NUM_REGS));
    assign wr_fire = PSEL_I && PENABLE_I && PWRITE_I && pready_reg;
    assign wmask = (word_idx[2:0] == scfg_pkg::IDX_REMOTE_ADDR) ? scfg_pkg::MASK_REMOTE : scfg_pkg::MASK_FULL;

    // one wait-free answer after setup; held off until the straps are loaded
    always_comb begin
        pready_next = PSEL_I && (state_reg == scfg_pkg::SCFG_RUN) && !pready_reg;
        pslverr_next = pready_next && !mapped;
        prdata_next = prdata_reg;
        if (pready_next) begin
            prdata_next = (mapped && !PWRITE_I) ? {24'h00_0000, regs_reg[word_idx[2:0]]} : 32'h0000_0000;
        end
    end

    // register contents: strap defaults, then software writes
    always_comb begin
        for (int i = 0; i < scfg_pkg::NUM_REGS; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (load_now) begin
            regs_next[scfg_pkg::IDX_LOCAL_ADDR] = {strap_high, scfg_pkg::LOCAL_ADDR_MID, strap_low, 1'b0, 1'b0};
            regs_next[scfg_pkg::IDX_REMOTE_ADDR] = {strap_high, scfg_pkg::REMOTE_ADDR_MID, strap_low, 1'b0, 1'b0};
            regs_next[scfg_pkg::IDX_SPREAD_AUDIO] = scfg_pkg::SPREAD_AUDIO_RST;
            regs_next[scfg_pkg::IDX_SPREAD_AUDIO][scfg_pkg::SPREAD_LSB +: 3] =
                spread_pin ? scfg_pkg::SPREAD_PIN_CODE : 3'h0;
            regs_next[scfg_pkg::IDX_SPREAD_CAL] = scfg_pkg::SPREAD_CAL_RST;
            // link default from auto start pin
            regs_next[scfg_pkg::IDX_LINK_CTRL] = scfg_pkg::LINK_CTRL_RST;
            regs_next[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::SER_BIT] = !auto_start_pin;
            regs_next[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::SLEEP_BIT] = auto_start_pin && control_side_pin;
        end else if (wr_fire && mapped && PSTRB_I[0] &&
                     !(regs_reg[scfg_pkg::IDX_LOCAL_ADDR][scfg_pkg::LOCK_BIT] &&
                       {{(32-ADDR_W){1'b0}}, PADDR_I[ADDR_W-1:2], 2'h0} <= {22'h0, scfg_pkg::LOCK_LAST_IDX, 2'h0})) begin
            regs_next[word_idx[2:0]] = (PWDATA_I[7:0] & wmask) | (regs_reg[word_idx[2:0]] & ~wmask);
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < scfg_pkg::NUM_REGS; i++) begin
                regs_reg[i] <= 8'h00;
            end
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < scfg_pkg::NUM_REGS; i++) begin
                regs_reg[i] <= regs_next[i];
            end
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // ******************************************
    // reverse channel hold after link start or stop
    // ******************************************
    logic [16:0] hold_reg, hold_next;
    logic ser_on_next;
    assign ser_on_next = regs_next[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::SER_BIT];

    always_comb begin
        hold_next = hold_reg;
        if (state_reg == scfg_pkg::SCFG_RUN && ser_on_next != regs_reg[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::SER_BIT]) begin
            hold_next = 17'(REVCC_HOLD_CYC);
        end else if (hold_reg != 17'h0_0000) begin
            hold_next = hold_reg - 17'h0_0001;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            hold_reg <= 17'h0_0000;
        end else begin
            hold_reg <= hold_next;
        end
    end

    // ******************************************
    // spread rate recalibration timer
    // ******************************************
    logic [26:0] recal_cnt_reg, recal_cnt_next;
    logic lock_d_reg, lock_d_next;
    logic recal_reg, recal_next;
    logic [26:0] recal_period;
    logic [1:0] recal_sel;
    assign recal_sel = regs_reg[scfg_pkg::IDX_SPREAD_CAL][scfg_pkg::RECAL_LSB +: 2];

    always_comb begin
        case (recal_sel)
            scfg_pkg::RECAL_2MS: recal_period = 27'(RECAL_2MS_CYC);
            scfg_pkg::RECAL_16MS: recal_period = 27'(RECAL_16MS_CYC);
            default: recal_period = 27'(RECAL_256MS_CYC);
        endcase
        lock_d_next = link_lock;
        recal_next = 1'b0;
        recal_cnt_next = 27'h000_0000;
        // one pulse at lock, then periodic unless in once mode
        if (link_lock && !lock_d_reg) begin
            recal_next = 1'b1;
        end else if (link_lock && recal_sel != scfg_pkg::RECAL_ONCE) begin
            if (recal_cnt_reg >= recal_period - 27'h000_0001) begin
                recal_next = 1'b1;
            end else begin
                recal_cnt_next = recal_cnt_reg + 27'h000_0001;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            recal_cnt_reg <= 27'h000_0000;
            lock_d_reg <= 1'b0;
            recal_reg <= 1'b0;
        end else begin
            recal_cnt_reg <= recal_cnt_next;
            lock_d_reg <= lock_d_next;
            recal_reg <= recal_next;
        end
    end

    // ******************************************
    // registered configuration outputs
    // ******************************************
    logic [7:0] r2n, r3n, r4n;
    logic [3:0] spread_reg, spread_next;
    logic [4:0] dec_reg, dec_next;
    assign r2n = regs_next[scfg_pkg::IDX_SPREAD_AUDIO];
    assign r3n = regs_next[scfg_pkg::IDX_SPREAD_CAL];
    assign r4n = regs_next[scfg_pkg::IDX_LINK_CTRL];

    // decoded flags track the fields they come from in the same cycle
    always_comb begin
        spread_next = scfg_pkg::SPREAD_HALF_PCT[r2n[scfg_pkg::SPREAD_LSB +: 3]];
        dec_next[0] = r2n[scfg_pkg::PCLK_LSB +: 2] == scfg_pkg::RANGE_AUTO;
        dec_next[1] = r2n[scfg_pkg::RATE_LSB +: 2] == scfg_pkg::RANGE_AUTO;
        dec_next[2] = r3n[scfg_pkg::SAW_LSB +: 6] == scfg_pkg::SAW_AUTO;
        dec_next[3] = r4n[scfg_pkg::PERIPH_LSB +: 2] == scfg_pkg::PERIPH_I2C;
        dec_next[4] = r4n[scfg_pkg::PERIPH_LSB +: 2] == scfg_pkg::PERIPH_UART;
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            spread_reg <= 4'h0;
            dec_reg <= 5'h00;
        end else begin
            spread_reg <= spread_next;
            dec_reg <= dec_next;
        end
    end

    logic rev_reg;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rev_reg <= 1'b0;
        end else begin
            rev_reg <= r4n[scfg_pkg::REV_BIT] && (hold_next == 17'h0_0000);
        end
    end

    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign LOCAL_DEV_ADDR_O = regs_reg[scfg_pkg::IDX_LOCAL_ADDR][scfg_pkg::ADDR_LSB +: 7];
    assign REMOTE_DEV_ADDR_O = regs_reg[scfg_pkg::IDX_REMOTE_ADDR][scfg_pkg::ADDR_LSB +: 7];
    assign CONFIG_WRITE_LOCK_O = regs_reg[scfg_pkg::IDX_LOCAL_ADDR][scfg_pkg::LOCK_BIT];
    assign SPREAD_HALF_PCT_O = spread_reg;
    assign PIXEL_CLK_RANGE_O = regs_reg[scfg_pkg::IDX_SPREAD_AUDIO][scfg_pkg::PCLK_LSB +: 2];
    assign PIXEL_CLK_AUTO_O = dec_reg[0];
    assign SERIAL_RATE_RANGE_O = regs_reg[scfg_pkg::IDX_SPREAD_AUDIO][scfg_pkg::RATE_LSB +: 2];
    assign SERIAL_RATE_AUTO_O = dec_reg[1];
    assign SPREAD_RECAL_O = recal_reg;
    assign SAWTOOTH_DIVIDER_O = regs_reg[scfg_pkg::IDX_SPREAD_CAL][scfg_pkg::SAW_LSB +: 6];
    assign SAWTOOTH_AUTO_O = dec_reg[2];
    assign AUDIO_CHANNEL_ON_O = regs_reg[scfg_pkg::IDX_SPREAD_AUDIO][scfg_pkg::AUDIO_BIT];
    assign SERIAL_LINK_ON_O = regs_reg[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::SER_BIT];
    assign CONFIG_LINK_ON_O = regs_reg[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::CLINK_BIT];
    assign PRBS_TEST_ON_O = regs_reg[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::PRBS_BIT];
    assign SLEEP_O = regs_reg[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::SLEEP_BIT];
    assign PERIPH_I2C_O = dec_reg[3];
    assign PERIPH_UART_O = dec_reg[4];
    assign REVERSE_CHANNEL_ON_O = rev_reg;
    assign FORWARD_CHANNEL_ON_O = regs_reg[scfg_pkg::IDX_LINK_CTRL][scfg_pkg::FWD_BIT];
endmodule

// *** hw/scfg_sync.sv ***
`timescale 1ns/10ps
module scfg_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // asynchronous level in, synchronised level out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // two flops; only the second reads the first
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

// *** verif/scfg_regs_properties.sv ***
`timescale 1ns/10ps
// ****************************************
// register bank checker
// ****************************************
module scfg_regs_properties #(
    parameter int ADDR_W = 12
) (
    // clock, reset and bus
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    // lock status and configuration
    input wire logic LINK_LOCK_I,
    input wire logic [6:0] LOCAL_DEV_ADDR_O,
    input wire logic [6:0] REMOTE_DEV_ADDR_O,
    input wire logic CONFIG_WRITE_LOCK_O,
    input wire logic [1:0] PIXEL_CLK_RANGE_O,
    input wire logic PIXEL_CLK_AUTO_O,
    input wire logic [1:0] SERIAL_RATE_RANGE_O,
    input wire logic SERIAL_RATE_AUTO_O,
    input wire logic SPREAD_RECAL_O,
    input wire logic [5:0] SAWTOOTH_DIVIDER_O,
    input wire logic SAWTOOTH_AUTO_O,
    input wire logic AUDIO_CHANNEL_ON_O,
    input wire logic SERIAL_LINK_ON_O,
    input wire logic CONFIG_LINK_ON_O,
    input wire logic PRBS_TEST_ON_O,
    input wire logic SLEEP_O,
    input wire logic PERIPH_I2C_O,
    input wire logic PERIPH_UART_O,
    input wire logic REVERSE_CHANNEL_ON_O,
    input wire logic FORWARD_CHANNEL_ON_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RSTN_I);
    // a completed read shows the register that drives the decoded outputs
    wire logic rd_done = PREADY_O && PENABLE_I && !PWRITE_I;
    wire logic [7:0] d = PRDATA_O[7:0];
    property p_addr_read;
        rd_done && PADDR_I == ADDR_W'(12'h000) |-> LOCAL_DEV_ADDR_O == d[7:1] && CONFIG_WRITE_LOCK_O == d[0];
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("local address output differs");
    property p_remote_read;
        rd_done && PADDR_I == ADDR_W'(12'h004) |-> REMOTE_DEV_ADDR_O == d[7:1] && d[0] == 1'b0;
    endproperty
    a_remote_read: assert property (p_remote_read) else $error("remote address output differs");
    property p_range_read;
        rd_done && PADDR_I == ADDR_W'(12'h008) |-> PIXEL_CLK_RANGE_O == d[3:2] && PIXEL_CLK_AUTO_O == (d[3:2] == 2'h3)
            && SERIAL_RATE_RANGE_O == d[1:0] && SERIAL_RATE_AUTO_O == (d[1:0] == 2'h3) && AUDIO_CHANNEL_ON_O == d[4];
    endproperty
    a_range_read: assert property (p_range_read) else $error("range outputs differ");
    property p_saw_read;
        rd_done && PADDR_I == ADDR_W'(12'h00C) |-> SAWTOOTH_DIVIDER_O == d[5:0] && SAWTOOTH_AUTO_O == (d[5:0] == 6'h0);
    endproperty
    a_saw_read: assert property (p_saw_read) else $error("divider outputs differ");
    property p_ctrl_read;
        rd_done && PADDR_I == ADDR_W'(12'h010) |-> SERIAL_LINK_ON_O == d[7] && SLEEP_O == d[4]
            && CONFIG_LINK_ON_O == d[6] && PRBS_TEST_ON_O == d[5] && FORWARD_CHANNEL_ON_O == d[0]
            && PERIPH_I2C_O == (d[3:2] == 2'h0) && PERIPH_UART_O == (d[3:2] == 2'h1) && (!REVERSE_CHANNEL_ON_O || d[1]);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control outputs differ");
    property p_lock; CONFIG_WRITE_LOCK_O |=> CONFIG_WRITE_LOCK_O && $stable(SAWTOOTH_DIVIDER_O) && $stable(SLEEP_O); endproperty
    a_lock: assert property (p_lock) else $error("locked register changed");
    property p_link_hold;
        $changed(SERIAL_LINK_ON_O) && $past(PREADY_O && PWRITE_I) |-> !REVERSE_CHANNEL_ON_O [*8];
    endproperty
    a_link_hold: assert property (p_link_hold) else $error("reverse channel not held off");
    property p_recal; $rose(LINK_LOCK_I) |-> ##[2:4] SPREAD_RECAL_O; endproperty
    a_recal: assert property (p_recal) else $error("no recalibration after lock");
    // main scenarios reached
    c_lock: cover property (CONFIG_WRITE_LOCK_O);
    c_hold: cover property ($fell(REVERSE_CHANNEL_ON_O));
    c_recal: cover property (SPREAD_RECAL_O);
endmodule

// *** verif/test_scfg_regs.sv ***
`timescale 1ns/10ps
// ****************************************
// register bank bench
// ****************************************
module test_scfg_regs;
    typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] q;} scfg_row_t;
    // bus, pins and observed outputs
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic lock_in = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    // straps: control side, auto start, spread, address high, address low
    logic [6:0] pins = 7'h56;
    logic [31:0] prdata, r;
    logic pready, pslverr, e, wlock, recal, serial_on, sleep, rev_on;
    logic [6:0] loc_addr, rem_addr;
    logic [3:0] spread;
    int n_errors = 0;
    int checks = 0;
    int cnt;
    // write value and expected read back, remote bit 0 reads zero
    scfg_row_t rows [12] = '{'{12'h000, 8'h5A, 8'h5A}, '{12'h004, 8'h33, 8'h32}, '{12'h004, 8'hFF, 8'hFE},
        '{12'h008, 8'hA7, 8'hA7}, '{12'h008, 8'h10, 8'h10}, '{12'h008, 8'h09, 8'h09}, '{12'h008, 8'h4E, 8'h4E},
        '{12'h00C, 8'hC5, 8'hC5}, '{12'h010, 8'hE4, 8'hE4}, '{12'h010, 8'h9B, 8'h9B}, '{12'h010, 8'h8F, 8'h8F},
        '{12'h00C, 8'h00, 8'h00}};
    logic [7:0] dflt [5] = '{8'h48, 8'h58, 8'h3F, 8'h00, 8'h83};
    logic [3:0] half_pct [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h0, 4'h2, 4'h6, 4'h8};
    int recal_n [4] = '{1, 6, 4, 3};
    // short hold and periods keep the run brief
    scfg_regs #(.REVCC_HOLD_CYC(20), .RECAL_2MS_CYC(30), .RECAL_16MS_CYC(50), .RECAL_256MS_CYC(80)) u_dut (
        .SYS_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .ADDR_STRAP_LOW_I(pins[1:0]), .ADDR_STRAP_HIGH_I(pins[3:2]), .SPREAD_PIN_I(pins[4]), .AUTO_START_PIN_I(pins[5]),
        .CONTROL_SIDE_PIN_I(pins[6]), .LINK_LOCK_I(lock_in), .LOCAL_DEV_ADDR_O(loc_addr), .REMOTE_DEV_ADDR_O(rem_addr),
        .CONFIG_WRITE_LOCK_O(wlock), .SPREAD_HALF_PCT_O(spread), .PIXEL_CLK_RANGE_O(), .PIXEL_CLK_AUTO_O(),
        .SERIAL_RATE_RANGE_O(), .SERIAL_RATE_AUTO_O(), .SPREAD_RECAL_O(recal), .SAWTOOTH_DIVIDER_O(),
        .SAWTOOTH_AUTO_O(), .AUDIO_CHANNEL_ON_O(), .SERIAL_LINK_ON_O(serial_on), .CONFIG_LINK_ON_O(),
        .PRBS_TEST_ON_O(), .SLEEP_O(sleep), .PERIPH_I2C_O(), .PERIPH_UART_O(), .REVERSE_CHANNEL_ON_O(rev_on),
        .FORWARD_CHANNEL_ON_O());
    always #2 clk = ~clk;
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one transfer; the idle edge after it keeps drivers from double assignment
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] dat);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, dat};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the expected run
    initial begin
        #40000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk);
        chk("addr_in_reset", 32'(loc_addr), 32'h0);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(4 * i), 8'h00);
            chk("default", r, 32'(dflt[i]));
        end
        chk("local_addr", 32'(loc_addr), 32'h24);
        chk("remote_addr", 32'(rem_addr), 32'h2C);
        chk("link_sleep_rev", 32'({serial_on, sleep, rev_on}), 32'h5);
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 8'h00);
            chk("readback", r, 32'(rows[i].q));
        end
        chk("rev_no_hold", 32'(rev_on), 32'h1);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 12'h008, {3'(c), 5'h1F});
            chk("spread", 32'(spread), 32'(half_pct[c]));
        end
        // dead lane and misaligned write leave the divider
        pstrb <= 4'h0;
        apb(1'b1, 12'h00C, 8'h3C);
        pstrb <= 4'hF;
        apb(1'b1, 12'h00D, 8'h3C);
        apb(1'b0, 12'h00C, 8'h00);
        chk("divider", r, 32'h0);
        apb(1'b0, 12'h014, 8'h00);
        chk("unmapped", {r[30:0], e}, 32'h1);
        // stopping the link blanks the reverse channel
        apb(1'b1, 12'h010, 8'h03);
        repeat (19) @(posedge clk);
        chk("rev_held", 32'({serial_on, rev_on}), 32'h0);
        @(posedge clk);
        chk("rev_back", 32'(rev_on), 32'h1);
        // pulses per interval code after lock
        for (int m = 0; m < 4; m++) begin
            lock_in <= 1'b0;
            apb(1'b1, 12'h00C, {2'(m), 6'h00});
            lock_in <= 1'b1;
            cnt = 0;
            repeat (170) begin
                @(posedge clk);
                if (recal === 1'b1) cnt++;
            end
            chk("recal_count", 32'(cnt), 32'(recal_n[m]));
        end
        apb(1'b1, 12'h000, 8'h01);
        apb(1'b1, 12'h000, 8'h00);
        apb(1'b1, 12'h00C, 8'h15);
        apb(1'b0, 12'h00C, 8'h00);
        chk("locked_reg", r, 32'hC0);
        chk("lock_out", 32'(wlock), 32'h1);
        rstn <= 1'b0;
        pins <= 7'h6C;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, 12'h000, 8'h00);
        chk("after_reset", r, 32'hC0);
        apb(1'b0, 12'h008, 8'h00);
        chk("pin_low", r, 32'h1F);
        apb(1'b0, 12'h010, 8'h00);
        chk("pin_high", r, 32'h13);
        end_sim();
    end
endmodule
bind scfg_regs scfg_regs_properties #(.ADDR_W(ADDR_W)) u_props (
    .SYS_CLK_I, .RSTN_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O, .LINK_LOCK_I, .LOCAL_DEV_ADDR_O,
    .REMOTE_DEV_ADDR_O, .CONFIG_WRITE_LOCK_O, .PIXEL_CLK_RANGE_O, .PIXEL_CLK_AUTO_O, .SERIAL_RATE_RANGE_O,
    .SERIAL_RATE_AUTO_O, .SPREAD_RECAL_O, .SAWTOOTH_DIVIDER_O, .SAWTOOTH_AUTO_O, .AUDIO_CHANNEL_ON_O,
    .CONFIG_LINK_ON_O, .PRBS_TEST_ON_O,
    .SERIAL_LINK_ON_O, .SLEEP_O, .PERIPH_I2C_O, .PERIPH_UART_O, .REVERSE_CHANNEL_ON_O, .FORWARD_CHANNEL_ON_O);
